// >>> hw/alod_pkg.sv
// Package of opcode, operation, source and timing constants for the arithmetic/logic decoder
package alod_pkg;

  // Operation selected for the ALU datapath
  typedef enum logic [4:0] {
    ALOD_OP_NONE = 5'h00, // Opcode outside these groups
    ALOD_OP_ADD = 5'h01, // Plain addition
    ALOD_OP_ADD_WITH_CARRY = 5'h02, // Addition including carry
    ALOD_OP_SUBTRACT_WITH_BORROW = 5'h03, // Subtraction with borrow
    ALOD_OP_INC = 5'h04, // Add one
    ALOD_OP_SUBTRACT_ONE = 5'h05, // Subtract one
    ALOD_OP_INC_POINTER = 5'h06, // 16-bit pointer increment
    ALOD_OP_PRODUCT_OF_A_B = 5'h07, // Multiply A by B
    ALOD_OP_DIVIDE = 5'h08, // Divide A by B
    ALOD_OP_BCD_CORRECT = 5'h09, // Decimal adjust
    ALOD_OP_BITWISE_AND = 5'h0a, // AND
    ALOD_OP_BITWISE_OR = 5'h0b, // OR
    ALOD_OP_BITWISE_XOR = 5'h0c, // Exclusive OR
    ALOD_OP_CLEAR = 5'h0d, // Clear accumulator
    ALOD_OP_BITWISE_INVERT = 5'h0e, // Complement accumulator
    ALOD_OP_ROTATE_LEFT = 5'h0f, // Rotate left
    ALOD_OP_ROTATE_LEFT_THROUGH_CARRY = 5'h10, // Rotate left via carry
    ALOD_OP_ROTATE_RIGHT = 5'h11, // Rotate right
    ALOD_OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h12, // Rotate right via carry
    ALOD_OP_SWAP_NIBBLES = 5'h13 // Exchange nibbles
  } alod_op_t;

  // Operand source form
  typedef enum logic [2:0] {
    ALOD_SRC_NONE = 3'h0, // No memory operand
    ALOD_SRC_BANK_REGISTER = 3'h1, // Bank register selected by low bits
    ALOD_SRC_DIRECT = 3'h2, // Direct byte
    ALOD_SRC_INDIRECT = 3'h3, // RAM through pointer register
    ALOD_SRC_IMMEDIATE = 3'h4, // Immediate data
    ALOD_SRC_ACC = 3'h5, // Accumulator
    ALOD_SRC_DATA_POINTER_16 = 3'h6, // 16-bit data pointer
    ALOD_SRC_B_REG = 3'h7 // A with B register
  } alod_src_t;

  // Destination of the result
  typedef enum logic [1:0] {
    ALOD_DST_ACC = 2'h0, // Accumulator
    ALOD_DST_DIRECT = 2'h1, // Direct byte
    ALOD_DST_OPERAND = 2'h2, // Same place as the source
    ALOD_DST_PAIR = 2'h3 // Pair of A and B, or pointer
  } alod_dst_t;

  // Decoded instruction record
  typedef struct packed {
    logic valid; // Opcode belongs to these groups
    alod_op_t op; // Operation
    alod_src_t src; // Operand source
    alod_dst_t dst; // Destination
    logic [2:0] reg_sel; // Bank register or pointer register number
    logic [1:0] length; // Bytes in instruction
    logic [2:0] cycles; // Execution cycles
  } alod_dec_t;

  // Lengths and cycle counts
  localparam logic [1:0] ALOD_LEN_1 = 2'h1;
  localparam logic [1:0] ALOD_LEN_2 = 2'h2;
  localparam logic [1:0] ALOD_LEN_3 = 2'h3;
  localparam logic [2:0] ALOD_CYC_1 = 3'h1;
  localparam logic [2:0] ALOD_CYC_2 = 3'h2;
  localparam logic [2:0] ALOD_CYC_4 = 3'h4;

  // Row codes in the upper nibble for register-form groups
  localparam logic [3:0] ALOD_ROW_INC = 4'h0;
  localparam logic [3:0] ALOD_ROW_DEC = 4'h1;
  localparam logic [3:0] ALOD_ROW_ADD = 4'h2;
  localparam logic [3:0] ALOD_ROW_ADD_WITH_CARRY = 4'h3;
  localparam logic [3:0] ALOD_ROW_OR = 4'h4;
  localparam logic [3:0] ALOD_ROW_AND = 4'h5;
  localparam logic [3:0] ALOD_ROW_XOR = 4'h6;
  localparam logic [3:0] ALOD_ROW_SUB = 4'h9;

  // Single opcodes
  localparam logic [7:0] ALOD_OPC_RR = 8'h03;
  localparam logic [7:0] ALOD_OPC_RRC = 8'h13;
  localparam logic [7:0] ALOD_OPC_RL = 8'h23;
  localparam logic [7:0] ALOD_OPC_RLC = 8'h33;
  localparam logic [7:0] ALOD_OPC_OR_DA = 8'h42;
  localparam logic [7:0] ALOD_OPC_OR_DI = 8'h43;
  localparam logic [7:0] ALOD_OPC_AND_DA = 8'h52;
  localparam logic [7:0] ALOD_OPC_AND_DI = 8'h53;
  localparam logic [7:0] ALOD_OPC_XOR_DA = 8'h62;
  localparam logic [7:0] ALOD_OPC_XOR_DI = 8'h63;
  localparam logic [7:0] ALOD_OPC_DIV = 8'h84;
  localparam logic [7:0] ALOD_OPC_INC_DP = 8'ha3;
  localparam logic [7:0] ALOD_OPC_MUL = 8'ha4;
  localparam logic [7:0] ALOD_OPC_SWAP = 8'hc4;
  localparam logic [7:0] ALOD_OPC_BCD = 8'hd4;
  localparam logic [7:0] ALOD_OPC_CLR = 8'he4;
  localparam logic [7:0] ALOD_OPC_CPL = 8'hf4;

  // Low nibble column codes
  localparam logic [3:0] ALOD_COL_ACC = 4'h4;
  localparam logic [3:0] ALOD_COL_DIRECT = 4'h5;

  // Reset value of the decoded record
  localparam alod_dec_t ALOD_DEC_RESET = '{valid: 1'b0, op: ALOD_OP_NONE, src: ALOD_SRC_NONE,
    dst: ALOD_DST_ACC, reg_sel: 3'h0, length: ALOD_LEN_1, cycles: ALOD_CYC_1};

endpackage : alod_pkg

// >>> hw/alod_table.sv
// Combinational opcode table for the arithmetic and logic groups
`timescale 1ns/1ps
module alod_table (
  input wire logic [7:0] opcode, // First byte of instruction
  output alod_pkg::alod_dec_t dec // Decoded record
);

  // Nibble split of the opcode
  logic [3:0] row;
  logic [3:0] col;
  // Operation implied by row for the four-form groups
  alod_pkg::alod_op_t row_op;
  logic row_known;

  assign row = opcode[7:4];
  assign col = opcode[3:0];

  // Row to operation map
  always_comb
  begin
    row_known = 1'b1;
    unique case (row)
      alod_pkg::ALOD_ROW_ADD: row_op = alod_pkg::ALOD_OP_ADD; // RULE_01
      alod_pkg::ALOD_ROW_ADD_WITH_CARRY: row_op = alod_pkg::ALOD_OP_ADD_WITH_CARRY; // RULE_02
      alod_pkg::ALOD_ROW_SUB: row_op = alod_pkg::ALOD_OP_SUBTRACT_WITH_BORROW; // RULE_03
      alod_pkg::ALOD_ROW_AND: row_op = alod_pkg::ALOD_OP_BITWISE_AND; // RULE_04
      alod_pkg::ALOD_ROW_OR: row_op = alod_pkg::ALOD_OP_BITWISE_OR; // RULE_06
      alod_pkg::ALOD_ROW_XOR: row_op = alod_pkg::ALOD_OP_BITWISE_XOR; // RULE_08
      alod_pkg::ALOD_ROW_INC: row_op = alod_pkg::ALOD_OP_INC; // RULE_15
      alod_pkg::ALOD_ROW_DEC: row_op = alod_pkg::ALOD_OP_SUBTRACT_ONE; // RULE_15
      default:
      begin
        // Rows of other instruction groups
        row_op = alod_pkg::ALOD_OP_NONE;
        row_known = 1'b0;
      end
    endcase
  end

  // Full decode; single opcodes are checked before the column forms
  always_comb
  begin
    dec = alod_pkg::ALOD_DEC_RESET;
    dec.reg_sel = opcode[2:0];
    if (opcode == alod_pkg::ALOD_OPC_AND_DA || opcode == alod_pkg::ALOD_OPC_OR_DA ||
        opcode == alod_pkg::ALOD_OPC_XOR_DA)
    begin
      // Accumulator into direct byte: two bytes, one cycle
      dec = '{1'b1, row_op, alod_pkg::ALOD_SRC_ACC, alod_pkg::ALOD_DST_DIRECT, 3'h0,
        alod_pkg::ALOD_LEN_2, alod_pkg::ALOD_CYC_1}; // RULE_05 RULE_07 RULE_09
    end
    else if (opcode == alod_pkg::ALOD_OPC_AND_DI || opcode == alod_pkg::ALOD_OPC_OR_DI ||
             opcode == alod_pkg::ALOD_OPC_XOR_DI)
    begin
      // Immediate into direct byte: three bytes, two cycles
      dec = '{1'b1, row_op, alod_pkg::ALOD_SRC_IMMEDIATE, alod_pkg::ALOD_DST_DIRECT, 3'h0,
        alod_pkg::ALOD_LEN_3, alod_pkg::ALOD_CYC_2}; // RULE_05 RULE_07 RULE_09
    end
    else if (opcode == alod_pkg::ALOD_OPC_INC_DP)
    begin
      dec = '{1'b1, alod_pkg::ALOD_OP_INC_POINTER, alod_pkg::ALOD_SRC_DATA_POINTER_16,
        alod_pkg::ALOD_DST_PAIR, 3'h0, alod_pkg::ALOD_LEN_1, alod_pkg::ALOD_CYC_2}; // RULE_15
    end
    else if (opcode == alod_pkg::ALOD_OPC_MUL || opcode == alod_pkg::ALOD_OPC_DIV)
    begin
      // Long multi-cycle arithmetic on A and B
      dec = '{1'b1, (opcode == alod_pkg::ALOD_OPC_MUL) ? alod_pkg::ALOD_OP_PRODUCT_OF_A_B :
        alod_pkg::ALOD_OP_DIVIDE, alod_pkg::ALOD_SRC_B_REG, alod_pkg::ALOD_DST_PAIR, 3'h0,
        alod_pkg::ALOD_LEN_1, alod_pkg::ALOD_CYC_4}; // RULE_16
    end
    else if (opcode == alod_pkg::ALOD_OPC_BCD || opcode == alod_pkg::ALOD_OPC_CLR ||
             opcode == alod_pkg::ALOD_OPC_CPL || opcode == alod_pkg::ALOD_OPC_SWAP ||
             opcode == alod_pkg::ALOD_OPC_RL || opcode == alod_pkg::ALOD_OPC_RLC ||
             opcode == alod_pkg::ALOD_OPC_RR || opcode == alod_pkg::ALOD_OPC_RRC)
    begin
      // One-byte accumulator-only operations
      dec.valid = 1'b1;
      dec.src = alod_pkg::ALOD_SRC_ACC;
      dec.reg_sel = 3'h0;
      unique case (opcode)
        alod_pkg::ALOD_OPC_BCD: dec.op = alod_pkg::ALOD_OP_BCD_CORRECT; // RULE_16
        alod_pkg::ALOD_OPC_CLR: dec.op = alod_pkg::ALOD_OP_CLEAR; // RULE_16
        alod_pkg::ALOD_OPC_CPL: dec.op = alod_pkg::ALOD_OP_BITWISE_INVERT; // RULE_16
        alod_pkg::ALOD_OPC_SWAP: dec.op = alod_pkg::ALOD_OP_SWAP_NIBBLES; // RULE_12
        alod_pkg::ALOD_OPC_RL: dec.op = alod_pkg::ALOD_OP_ROTATE_LEFT; // RULE_10
        alod_pkg::ALOD_OPC_RLC: dec.op = alod_pkg::ALOD_OP_ROTATE_LEFT_THROUGH_CARRY; // RULE_10
        alod_pkg::ALOD_OPC_RR: dec.op = alod_pkg::ALOD_OP_ROTATE_RIGHT; // RULE_11
        default: dec.op = alod_pkg::ALOD_OP_ROTATE_RIGHT_THROUGH_CARRY; // RULE_11
      endcase
    end
    else if (row_known)
    begin
      // Column forms shared by all four-form groups
      dec.valid = 1'b1;
      dec.op = row_op;
      dec.dst = (row == alod_pkg::ALOD_ROW_INC || row == alod_pkg::ALOD_ROW_DEC) ?
        alod_pkg::ALOD_DST_OPERAND : alod_pkg::ALOD_DST_ACC;
      if (col[3])
      begin
        dec.src = alod_pkg::ALOD_SRC_BANK_REGISTER; // RULE_13
      end
      else if (col[3:1] == 3'h3)
      begin
        dec.src = alod_pkg::ALOD_SRC_INDIRECT; // RULE_13
        dec.reg_sel = {2'h0, opcode[0]};
      end
      else if (col == alod_pkg::ALOD_COL_DIRECT)
      begin
        dec.src = alod_pkg::ALOD_SRC_DIRECT;
        dec.length = alod_pkg::ALOD_LEN_2; // RULE_13
      end
      else if (col == alod_pkg::ALOD_COL_ACC)
      begin
        // Column 4 is immediate data, but the accumulator for increment and decrement
        if (dec.dst == alod_pkg::ALOD_DST_OPERAND)
        begin
          dec.src = alod_pkg::ALOD_SRC_ACC; // RULE_15
        end
        else
        begin
          dec.src = alod_pkg::ALOD_SRC_IMMEDIATE;
          dec.length = alod_pkg::ALOD_LEN_2; // RULE_13
        end
      end
      else
      begin
        // Columns 0-3 of these rows belong to other groups
        dec = alod_pkg::ALOD_DEC_RESET;
      end
      if (!dec.valid)
      begin
        dec.reg_sel = 3'h0;
      end
    end
  end

endmodule : alod_table

// >>> hw/arith_logic_opcode_decoder.sv
// Registered arithmetic and logic opcode decoder with execution cycle sequencing
// Notes on behaviour
// RULE_01: 28-2F,25,26-27,24 add, one cycle each.
// RULE_02: 38-3F,35,36-37,34 add with carry, one cycle.
// RULE_03: 98-9F,95,96-97,94 subtract with borrow, one cycle.
// RULE_04: 58-5F,55,56-57,54 AND into accumulator, one cycle.
// RULE_05: 52 AND to direct; 53 immediate, 3B/2C.
// RULE_06: 48-4F,45,46-47,44 OR into accumulator, one cycle.
// RULE_07: 42 OR to direct; 43 immediate, 3B/2C.
// RULE_08: 68-6F,65,66-67,64 XOR into accumulator, one cycle.
// RULE_09: 62 XOR to direct; 63 immediate, 3B/2C.
// RULE_10: 23 rotate left, 33 through carry.
// RULE_11: 03 rotate right, 13 through carry.
// RULE_12: C4 swaps accumulator nibbles, one cycle.
// RULE_13: Register/indirect one byte; direct/immediate two bytes.
// RULE_14: Encodings and effects match the standard core.
// RULE_15: Increment/decrement four targets; A3 pointer two cycles.
// RULE_16: A4/84 four cycles; D4,E4,F4 one cycle.
`timescale 1ns/1ps
module arith_logic_opcode_decoder (
  input wire logic core_clk, // Core clock, 250 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic opcode_valid, // Fetch offers a first byte
  input wire logic [7:0] opcode, // First byte of instruction
  output logic opcode_ready_ff, // Decoder can take a new opcode
  output alod_pkg::alod_dec_t dec_ff, // Decoded record of current instruction
  output logic exec_ff, // Execution cycle in progress
  output logic last_cycle_ff, // This execution cycle is the final one
  output logic unknown_ff // Taken opcode is outside these groups, one pulse
);

  // Table output for the offered opcode
  alod_pkg::alod_dec_t table_dec;
  // Remaining cycles after the current one
  logic [2:0] remain_ff;
  logic [2:0] nxt_remain;
  alod_pkg::alod_dec_t nxt_dec;
  logic nxt_ready;
  logic nxt_exec;
  logic nxt_last;
  logic nxt_unknown;
  logic take;

  // Opcode table, kept apart so the sequencer stays readable
  alod_table u_table (
    .opcode(opcode),
    .dec(table_dec)
  );

  // Accepted when idle or on the final cycle, so one-cycle ops run back to back
  assign take = opcode_valid && opcode_ready_ff;

  // Next-state logic of the sequencer
  always_comb
  begin
    nxt_dec = dec_ff;
    nxt_remain = remain_ff;
    nxt_exec = exec_ff;
    nxt_last = last_cycle_ff;
    nxt_unknown = 1'b0;
    nxt_ready = opcode_ready_ff;
    if (take && table_dec.valid)
    begin
      // Start: the first execution cycle follows the accepting edge
      nxt_dec = table_dec; // RULE_14
      nxt_remain = table_dec.cycles - 3'h1;
      nxt_exec = 1'b1;
      nxt_last = (table_dec.cycles == alod_pkg::ALOD_CYC_1);
      nxt_ready = (table_dec.cycles == alod_pkg::ALOD_CYC_1);
    end
    else if (exec_ff && remain_ff != 3'h0)
    begin
      // Multi-cycle operation keeps going and holds off fetch
      nxt_remain = remain_ff - 3'h1;
      nxt_last = (remain_ff == 3'h1);
      nxt_ready = (remain_ff == 3'h1);
    end
    else
    begin
      // Idle; record stays for inspection but exec drops
      nxt_exec = 1'b0;
      nxt_last = 1'b0;
      nxt_ready = 1'b1;
      nxt_unknown = take;
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dec_ff <= alod_pkg::ALOD_DEC_RESET;
      remain_ff <= 3'h0;
      exec_ff <= 1'b0;
      last_cycle_ff <= 1'b0;
      unknown_ff <= 1'b0;
      opcode_ready_ff <= 1'b1;
    end
    else
    begin
      dec_ff <= nxt_dec;
      remain_ff <= nxt_remain;
      exec_ff <= nxt_exec;
      last_cycle_ff <= nxt_last;
      unknown_ff <= nxt_unknown;
      opcode_ready_ff <= nxt_ready;
    end
  end

  // Named steps of a four-cycle operation
  sequence mul_start_s;
    take && (opcode == alod_pkg::ALOD_OPC_MUL || opcode == alod_pkg::ALOD_OPC_DIV);
  endsequence
  sequence four_exec_s;
    (exec_ff && !opcode_ready_ff) [*3] ##1 (exec_ff && last_cycle_ff);
  endsequence

  add_direct_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_01
    take && opcode == 8'h25 |=> dec_ff.op == alod_pkg::ALOD_OP_ADD && dec_ff.length == 2'h2 && last_cycle_ff)
    else $error("add direct misdecoded");
  add_with_carry_reg_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_02
    take && opcode[7:3] == 5'h07 |=> dec_ff.op == alod_pkg::ALOD_OP_ADD_WITH_CARRY && dec_ff.cycles == 3'h1)
    else $error("add with carry register misdecoded");
  sub_imm_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_03
    take && opcode == 8'h94 |=> dec_ff.op == alod_pkg::ALOD_OP_SUBTRACT_WITH_BORROW &&
      dec_ff.src == alod_pkg::ALOD_SRC_IMMEDIATE)
    else $error("subtract immediate misdecoded");
  and_direct_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_05
    take && opcode == 8'h53 |=> !last_cycle_ff ##1 last_cycle_ff && dec_ff.length == 2'h3)
    else $error("and immediate to direct timing wrong");
  or_direct_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_07
    take && opcode == 8'h42 |=> dec_ff.dst == alod_pkg::ALOD_DST_DIRECT && dec_ff.length == 2'h2 && last_cycle_ff)
    else $error("or acc to direct misdecoded");
  rotate_ops_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_10
    take && opcode == 8'h33 |=> dec_ff.op == alod_pkg::ALOD_OP_ROTATE_LEFT_THROUGH_CARRY && dec_ff.length == 2'h1)
    else $error("rotate through carry misdecoded");
  indirect_len_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_13
    take && opcode[3:1] == 3'h3 && table_dec.valid |=> dec_ff.src == alod_pkg::ALOD_SRC_INDIRECT &&
      dec_ff.length == 2'h1 && dec_ff.reg_sel == {2'h0, $past(opcode[0])})
    else $error("indirect form wrong");
  pointer_inc_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_15
    take && opcode == 8'ha3 |=> !opcode_ready_ff && !last_cycle_ff ##1 last_cycle_ff && opcode_ready_ff &&
      dec_ff.op == alod_pkg::ALOD_OP_INC_POINTER)
    else $error("pointer increment timing wrong");
  mul_four_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_16
    mul_start_s |=> four_exec_s)
    else $error("multiply or divide not four cycles");

  // Single-cycle completion, seen in the cycle after taking
  sequence one_cycle_s;
    exec_ff && last_cycle_ff && opcode_ready_ff;
  endsequence

  // Bank-register AND; a wrong row map shows here first
  and_reg_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_04
    take && opcode[7:3] == 5'h0b |=> one_cycle_s ##0 dec_ff.op == alod_pkg::ALOD_OP_BITWISE_AND)
    else $error("and register misdecoded");
  // Indirect OR uses the pointer form
  or_indirect_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_06
    take && (opcode == 8'h46 || opcode == 8'h47) |=> one_cycle_s ##0 dec_ff.op == alod_pkg::ALOD_OP_BITWISE_OR)
    else $error("or indirect misdecoded");
  // Immediate XOR needs the second byte
  xor_imm_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_08
    take && opcode == 8'h64 |=> one_cycle_s ##0 dec_ff.op == alod_pkg::ALOD_OP_BITWISE_XOR &&
      dec_ff.src == alod_pkg::ALOD_SRC_IMMEDIATE && dec_ff.length == 2'h2)
    else $error("xor immediate misdecoded");
  // Immediate into direct byte holds fetch for one cycle
  xor_direct_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_09
    take && opcode == 8'h63 |=> !last_cycle_ff && !opcode_ready_ff ##1 last_cycle_ff && opcode_ready_ff &&
      dec_ff.op == alod_pkg::ALOD_OP_BITWISE_XOR && dec_ff.dst == alod_pkg::ALOD_DST_DIRECT)
    else $error("xor immediate to direct timing wrong");
  // Right rotate through carry
  rotate_right_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_11
    take && opcode == 8'h13 |=> one_cycle_s ##0 dec_ff.op == alod_pkg::ALOD_OP_ROTATE_RIGHT_THROUGH_CARRY)
    else $error("rotate right through carry misdecoded");
  // Nibble swap is one byte
  swap_nibbles_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_12
    take && opcode == 8'hc4 |=> one_cycle_s ##0 dec_ff.op == alod_pkg::ALOD_OP_SWAP_NIBBLES &&
      dec_ff.length == 2'h1)
    else $error("nibble swap misdecoded");
  // Foreign opcode: pulse, no execution, record untouched
  unknown_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_14
    take && !table_dec.valid |=> unknown_ff && !exec_ff && $stable(dec_ff))
    else $error("foreign opcode not flagged");
  // No pulse without a taken foreign opcode
  unknown_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_14
    !(take && !table_dec.valid) |=> !unknown_ff)
    else $error("spurious foreign opcode flag");
  // Accumulator increment writes back in place
  inc_acc_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_15
    take && opcode == 8'h04 |=> one_cycle_s ##0 dec_ff.src == alod_pkg::ALOD_SRC_ACC &&
      dec_ff.dst == alod_pkg::ALOD_DST_OPERAND)
    else $error("accumulator increment misdecoded");
  // Direct decrement carries an address byte
  dec_direct_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_15
    take && opcode == 8'h15 |=> one_cycle_s ##0 dec_ff.op == alod_pkg::ALOD_OP_SUBTRACT_ONE &&
      dec_ff.length == 2'h2)
    else $error("direct decrement misdecoded");
  // Decimal adjust, clear and complement touch only A
  acc_only_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_16
    take && (opcode == 8'hd4 || opcode == 8'he4 || opcode == 8'hf4) |=> one_cycle_s ##0
      dec_ff.length == 2'h1 && dec_ff.src == alod_pkg::ALOD_SRC_ACC)
    else $error("accumulator-only op misdecoded");

  // Fetch is held off in every cycle but the last
  busy_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_16
    exec_ff && !last_cycle_ff |-> !opcode_ready_ff)
    else $error("ready raised while busy");
  // Record must not move under a running operation
  record_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_16
    exec_ff && !last_cycle_ff |=> exec_ff && $stable(dec_ff))
    else $error("record changed while busy");

  // Every direct-source form (column 5) is two bytes long
  direct_len_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_13
    take && opcode[3:0] == 4'h5 && table_dec.valid |=> dec_ff.src == alod_pkg::ALOD_SRC_DIRECT &&
      dec_ff.length == 2'h2)
    else $error("direct form length wrong");


endmodule : arith_logic_opcode_decoder

// >>> test/testbench.sv
// Self-checking bench for the arithmetic and logic opcode decoder
`timescale 1ns/1ps
module testbench;
  logic core_clk; // 250 MHz core clock
  logic nrst; // Active-low reset
  logic opcode_valid; // Offer strobe
  logic [7:0] opcode; // Offered first byte
  logic opcode_ready_ff; // Decoder can take
  alod_pkg::alod_dec_t dec_ff; // Decoded record
  logic exec_ff; // Execution in progress
  logic last_cycle_ff; // Final execution cycle
  logic unknown_ff; // Outside these groups
  int miscompares; // Mismatch count
  int samples_checked; // Comparison count
  int cycle_count = 0; // Hang guard

  arith_logic_opcode_decoder DUT (
    .core_clk(core_clk),
    .nrst(nrst),
    .opcode_valid(opcode_valid),
    .opcode(opcode),
    .opcode_ready_ff(opcode_ready_ff),
    .dec_ff(dec_ff),
    .exec_ff(exec_ff),
    .last_cycle_ff(last_cycle_ff),
    .unknown_ff(unknown_ff)
  );

  // Free-running clock, 4 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Verdict in one place
  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // Single-bit flag compare
  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit

  // Record field compare, zero-extended
  task automatic cmp_field(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_field

  // Independent expectation; chk says whether the source form is pinned down
  function automatic void ref_decode(input logic [7:0] o, output logic vld, output alod_pkg::alod_op_t op,
    output alod_pkg::alod_src_t src, output logic chk, output logic [1:0] len, output logic [2:0] cyc,
    output alod_pkg::alod_dst_t dst);
    logic row_ok;
    row_ok = 1'b1;
    vld = 1'b1;
    chk = 1'b1;
    len = 2'h1;
    cyc = 3'h1;
    src = alod_pkg::ALOD_SRC_NONE;
    op = alod_pkg::ALOD_OP_NONE;
    dst = alod_pkg::ALOD_DST_ACC;
    // Row of the register-form groups
    case (o[7:4])
      4'h0: op = alod_pkg::ALOD_OP_INC;
      4'h1: op = alod_pkg::ALOD_OP_SUBTRACT_ONE;
      4'h2: op = alod_pkg::ALOD_OP_ADD;
      4'h3: op = alod_pkg::ALOD_OP_ADD_WITH_CARRY;
      4'h4: op = alod_pkg::ALOD_OP_BITWISE_OR;
      4'h5: op = alod_pkg::ALOD_OP_BITWISE_AND;
      4'h6: op = alod_pkg::ALOD_OP_BITWISE_XOR;
      4'h9: op = alod_pkg::ALOD_OP_SUBTRACT_WITH_BORROW;
      default: row_ok = 1'b0;
    endcase
    if (row_ok && o[3:0] >= 4'h4)
    begin
      // Column picks the operand form
      if (o[3])
        src = alod_pkg::ALOD_SRC_BANK_REGISTER;
      else if (o[3:1] == 3'h3)
        src = alod_pkg::ALOD_SRC_INDIRECT;
      else if (o[3:0] == 4'h5)
        src = alod_pkg::ALOD_SRC_DIRECT;
      else if (o[7:5] == 3'h0)
        src = alod_pkg::ALOD_SRC_ACC;
      else
        src = alod_pkg::ALOD_SRC_IMMEDIATE;
      len = (src == alod_pkg::ALOD_SRC_DIRECT || src == alod_pkg::ALOD_SRC_IMMEDIATE) ? 2'h2 : 2'h1;
      // Increment and decrement write back where they read
      if (o[7:5] == 3'h0)
        dst = alod_pkg::ALOD_DST_OPERAND;
    end
    else if (o[7:4] inside {4'h4, 4'h5, 4'h6} && o[3:1] == 3'h1)
    begin
      // Into a direct byte: accumulator or immediate
      src = alod_pkg::ALOD_SRC_ACC;
      if (o[0])
        src = alod_pkg::ALOD_SRC_IMMEDIATE;
      dst = alod_pkg::ALOD_DST_DIRECT;
      len = o[0] ? 2'h3 : 2'h2;
      cyc = o[0] ? 3'h2 : 3'h1;
    end
    else
    begin
      chk = 1'b0;
      op = alod_pkg::ALOD_OP_NONE;
      case (o)
        8'h03: op = alod_pkg::ALOD_OP_ROTATE_RIGHT;
        8'h13: op = alod_pkg::ALOD_OP_ROTATE_RIGHT_THROUGH_CARRY;
        8'h23: op = alod_pkg::ALOD_OP_ROTATE_LEFT;
        8'h33: op = alod_pkg::ALOD_OP_ROTATE_LEFT_THROUGH_CARRY;
        8'hc4: op = alod_pkg::ALOD_OP_SWAP_NIBBLES;
        8'hd4: op = alod_pkg::ALOD_OP_BCD_CORRECT;
        8'he4: op = alod_pkg::ALOD_OP_CLEAR;
        8'hf4: op = alod_pkg::ALOD_OP_BITWISE_INVERT;
        8'ha4: op = alod_pkg::ALOD_OP_PRODUCT_OF_A_B;
        8'h84: op = alod_pkg::ALOD_OP_DIVIDE;
        8'ha3: op = alod_pkg::ALOD_OP_INC_POINTER;
        default: vld = 1'b0;
      endcase
      // Long operations and their operand pairs
      if (o == 8'ha4 || o == 8'h84)
      begin
        cyc = 3'h4;
        chk = 1'b1;
        src = alod_pkg::ALOD_SRC_B_REG;
        dst = alod_pkg::ALOD_DST_PAIR;
      end
      if (o == 8'ha3)
      begin
        cyc = 3'h2;
        chk = 1'b1;
        src = alod_pkg::ALOD_SRC_DATA_POINTER_16;
        dst = alod_pkg::ALOD_DST_PAIR;
      end
    end
  endfunction : ref_decode

  // Offer one opcode at a falling edge and follow it to its last cycle; busy cycles may offer a refused byte
  task automatic check_op(input logic [7:0] o, input logic refuse);
    logic vld;
    alod_pkg::alod_op_t op;
    alod_pkg::alod_src_t src;
    logic chk;
    logic [1:0] len;
    logic [2:0] cyc;
    alod_pkg::alod_dst_t dst;
    alod_pkg::alod_dec_t prev;
    ref_decode(o, vld, op, src, chk, len, cyc, dst);
    prev = dec_ff;
    cmp_bit(opcode_ready_ff, 1'b1);
    opcode_valid = 1'b1;
    opcode = o;
    @(posedge core_clk);
    @(negedge core_clk);
    cmp_bit(unknown_ff, ~vld);
    if (!vld)
    begin
      // Outside the groups: record held, no execution
      cmp_field(24'(prev), 24'(dec_ff));
      cmp_bit(exec_ff, 1'b0);
    end
    else
    begin
      cmp_bit(dec_ff.valid, 1'b1);
      cmp_field(24'(dec_ff.length), 24'(len));
      cmp_field(24'(dec_ff.cycles), 24'(cyc));
      cmp_field(24'(dec_ff.dst), 24'(dst));
      if (chk)
        cmp_field(24'(dec_ff.src), 24'(src));
      if (src == alod_pkg::ALOD_SRC_BANK_REGISTER)
        cmp_field(24'(dec_ff.reg_sel), 24'(o[2:0]));
      if (src == alod_pkg::ALOD_SRC_INDIRECT)
        cmp_field(24'(dec_ff.reg_sel[0]), 24'(o[0]));
      for (int k = 1; k <= int'(cyc); k++)
      begin
        // Busy cycles: record stands, ready only in the final one
        cmp_bit(exec_ff, 1'b1);
        cmp_bit(last_cycle_ff, k == int'(cyc));
        cmp_bit(opcode_ready_ff, k == int'(cyc));
        cmp_field(24'(dec_ff.op), 24'(op));
        if (k < int'(cyc))
        begin
          opcode_valid = refuse;
          opcode = 8'h24;
          @(negedge core_clk);
        end
      end
    end
  endtask : check_op

  // Reset in the middle of a long operation
  task automatic reset_midway;
    check_op(8'ha4, 1'b0);
    // Second multiply taken in the last cycle, then cut in its second busy cycle
    opcode_valid = 1'b1;
    opcode = 8'ha4;
    @(negedge core_clk);
    opcode_valid = 1'b0;
    @(negedge core_clk);
    cmp_bit(exec_ff, 1'b1);
    cmp_bit(opcode_ready_ff, 1'b0);
    nrst = 1'b0;
    #1;
    cmp_bit(exec_ff, 1'b0);
    cmp_bit(opcode_ready_ff, 1'b1);
    cmp_bit(dec_ff.valid, 1'b0);
    @(negedge core_clk);
    nrst = 1'b1;
  endtask : reset_midway

  // Hang guard, far above the few hundred cycles needed
  always @(posedge core_clk)
  begin
    cycle_count++;
    if (cycle_count == 3000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    opcode_valid = 1'b0;
    opcode = 8'h00;
    miscompares = 0;
    samples_checked = 0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    cmp_bit(exec_ff, 1'b0);
    cmp_bit(last_cycle_ff, 1'b0);
    cmp_bit(unknown_ff, 1'b0);
    cmp_bit(dec_ff.valid, 1'b0);
    nrst = 1'b1;
    // Every byte back to back, odd ones offering a refused byte while busy
    for (int i = 0; i < 256; i++)
      check_op(8'(i), i[0]);
    opcode_valid = 1'b0;
    @(negedge core_clk);
    cmp_bit(exec_ff, 1'b0);
    cmp_bit(unknown_ff, 1'b0);
    reset_midway;
    check_op(8'h84, 1'b1);
    check_op(8'h53, 1'b1);
    check_op(8'h43, 1'b0);
    check_op(8'h63, 1'b1);
    opcode_valid = 1'b0;
    @(negedge core_clk);
    tally_and_finish;
  end
endmodule : testbench
